/* File: core/light_adc_integration_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module light_adc_integration_timer (
  // Oscillator clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the serial slave
  input wire integ_timer_pkg::cmd_t cmd,
  // Analog front end
  input wire logic [15:0] adc_value,
  output logic integrating,
  output integ_timer_pkg::source_t source,
  // Results toward the read path
  output integ_timer_pkg::result_t result,
  output logic result_valid,
  output logic period_done,
  output logic [2:0] read_bytes,
  output logic powered_down
);

  // Timing class of the period that is running
  typedef enum logic [1:0] {IDLE, INTERNAL, EXTERNAL} mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Internal state and decode nets
  // Mode register and its next value
  mode_t mode;
  mode_t next_mode;
  // Oscillator cycle counter and its next value
  logic [15:0] cycle_count;
  logic [15:0] next_count;
  // Length of the external period that ends in this cycle
  logic [15:0] finished_count;
  // Command classes
  logic is_int;
  logic is_ext;
  logic is_reset;
  logic is_sleep;
  // Source picked by a mode command
  logic is_d2;
  logic is_diff;
  // Period end strobes
  logic int_end;
  logic ext_end;
  // Counter starts again from zero
  logic restart;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  // The strobe is one cycle wide and comes from logic on this clock,
  // so it is used as it stands, without synchronising flip-flops.
  // internal timing codes
  assign is_int = cmd.valid && (cmd.code == integ_timer_pkg::CMD_INT_D1 ||
    cmd.code == integ_timer_pkg::CMD_INT_D2 ||
    cmd.code == integ_timer_pkg::CMD_INT_DIFF);
  assign is_ext = cmd.valid && (cmd.code == integ_timer_pkg::CMD_EXT_D1 ||
    cmd.code == integ_timer_pkg::CMD_EXT_D2 ||
    cmd.code == integ_timer_pkg::CMD_EXT_DIFF);
  // Reset command clears the counter and stops integration
  assign is_reset = cmd.valid &&
    (cmd.code == integ_timer_pkg::CMD_RESET);
  // Sleep command; any other command wakes the block again
  assign is_sleep = cmd.valid &&
    (cmd.code == integ_timer_pkg::CMD_POWER_DOWN);
  // second diode in either timing class
  assign is_d2 = (cmd.code == integ_timer_pkg::CMD_INT_D2) ||
    (cmd.code == integ_timer_pkg::CMD_EXT_D2);
  // diode difference in either timing class
  assign is_diff = (cmd.code == integ_timer_pkg::CMD_INT_DIFF) ||
    (cmd.code == integ_timer_pkg::CMD_EXT_DIFF);

  ////////////////////////////////////////////////////////////////////////////
  // Period end detection
  // A command arriving on the last internal cycle wins: the old period
  // is dropped rather than closed, so no result from a period that the
  // host has already abandoned ever reaches the read path.
  // last of the fixed internal cycles
  assign int_end = (mode == INTERNAL) &&
    (cycle_count == integ_timer_pkg::INT_LAST_CYCLE) && !cmd.valid;
  // next external command closes a running external period
  assign ext_end = (mode == EXTERNAL) && is_ext;
  // One-cycle strobe toward the read path
  assign period_done = int_end || ext_end;
  // period start, internal end and reset command clear the count
  assign restart = is_int || is_ext || int_end || is_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Status toward the read path
  // High while any period runs
  assign integrating = (mode != IDLE);
  // four bytes in external timing, otherwise two, so the read path refuses the count bytes
  assign read_bytes = (mode == EXTERNAL) ? integ_timer_pkg::READ_BYTES_EXT :
    integ_timer_pkg::READ_BYTES_INT;

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection
  // a mode command starts its class; any other command idles
  always_comb begin
    next_mode = mode;
    if (is_int) begin
      next_mode = INTERNAL;
    end else if (is_ext) begin
      next_mode = EXTERNAL;
    end else if (cmd.valid) begin
      next_mode = IDLE;
    end
  end

  // Mode register
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= IDLE;
    end else begin
      mode <= next_mode;
    end
  end

  // source register, changed only by a mode command
  // The ending period still carries the old source into the snapshot,
  // because the snapshot samples this register before it moves.
  always_ff @(posedge clk) begin
    if (rst) begin
      source <= integ_timer_pkg::SRC_D1;
    end else if (is_int || is_ext) begin
      if (is_d2) begin
        source <= integ_timer_pkg::SRC_D2;
      end else if (is_diff) begin
        source <= integ_timer_pkg::SRC_DIFF;
      end else begin
        source <= integ_timer_pkg::SRC_D1;
      end
    end
  end

  // Sleep flag
  always_ff @(posedge clk) begin
    if (rst) begin
      powered_down <= 1'b0;
    end else if (cmd.valid) begin
      powered_down <= is_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counter
  // clk is the oscillator; one step per oscillator cycle
  // the counter steps alike in both timing classes
  // 16-bit count; a period of 65536 cycles wraps to zero
  // The wrap is not flagged: keeping the period short is the host's duty,
  // and a wrapped count simply gives a wrong lux figure.
  always_comb begin
    next_count = cycle_count;
    if (restart) begin
      next_count = integ_timer_pkg::COUNT_ZERO;
    end else if (mode != IDLE) begin
      next_count = cycle_count + integ_timer_pkg::COUNT_ONE;
    end
  end

  // clear at period start, then step
  always_ff @(posedge clk) begin
    if (rst) begin
      cycle_count <= integ_timer_pkg::COUNT_ZERO;
    end else begin
      cycle_count <= next_count;
    end
  end

  // length of the ending period, the ending edge included
  // Internal periods report zero, as their count is not offered.
  assign finished_count = int_end ? integ_timer_pkg::COUNT_ZERO :
    cycle_count + integ_timer_pkg::COUNT_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // Result snapshot, held until the next completion
  // A read in mid-period sees the previous period's values untouched.
  // reading, count and source latched at one edge
  always_ff @(posedge clk) begin
    if (rst) begin
      result <= '0;
    end else if (period_done) begin
      result.sensor_reading <= adc_value;
      result.integration_cycle_count <= finished_count;
      result.external <= ext_end;
      result.source <= source;
    end
  end

  // Set by the first completed period, then held
  always_ff @(posedge clk) begin
    if (rst) begin
      result_valid <= 1'b0;
    end else if (period_done) begin
      result_valid <= 1'b1;
    end
  end

endmodule : light_adc_integration_timer

`default_nettype wire

/* File: core/integ_timer_pkg.sv */
package integ_timer_pkg;

  // Command codes accepted from the command decoder
  localparam logic [7:0] CMD_INT_D1 = 8'h00;
  localparam logic [7:0] CMD_INT_D2 = 8'h04;
  localparam logic [7:0] CMD_INT_DIFF = 8'h08;
  localparam logic [7:0] CMD_RESET = 8'h0c;
  localparam logic [7:0] CMD_EXT_D1 = 8'h30;
  localparam logic [7:0] CMD_EXT_D2 = 8'h34;
  localparam logic [7:0] CMD_EXT_DIFF = 8'h38;
  localparam logic [7:0] CMD_POWER_DOWN = 8'h8c;

  // Oscillator and integration figures
  localparam int OSC_FREQ_KHZ = 300;
  localparam int INT_PERIOD_MS = 110;
  localparam logic [15:0] INT_LAST_CYCLE = 16'h7fff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Bytes per read in each timing class
  localparam logic [2:0] READ_BYTES_INT = 3'h2;
  localparam logic [2:0] READ_BYTES_EXT = 3'h4;

  // Conversion source
  typedef enum logic [1:0] {SRC_D1, SRC_D2, SRC_DIFF} source_t;

  // Decoded command strobe from the serial slave
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } cmd_t;

  // Result snapshot handed to the read path
  typedef struct packed {
    logic [15:0] sensor_reading;
    logic [15:0] integration_cycle_count;
    logic external;
    source_t source;
  } result_t;

endpackage : integ_timer_pkg

/* File: test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Command strobe toward the block
  output var integ_timer_pkg::cmd_t cmd
);
  initial cmd = '0;
  // spaced command strobes, code inverted when idle
  task automatic send(input logic [7:0] code, input int gap);
    @(negedge clk) cmd <= '{1'b1, code};
    @(negedge clk) cmd <= '{1'b0, ~code};
    repeat (gap) @(negedge clk);
  endtask : send
endmodule : host_model
`default_nettype wire

/* File: test/integ_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module integ_timer_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire integ_timer_pkg::cmd_t cmd,
  input wire logic [15:0] adc_value,
  input wire logic integrating,
  input wire integ_timer_pkg::source_t source,
  input wire integ_timer_pkg::result_t result,
  input wire logic result_valid,
  input wire logic period_done,
  input wire logic [2:0] read_bytes
);
  logic [15:0] run;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Edges since the current period began
  always_ff @(posedge clk) begin
    if (rst || cmd.valid || period_done) run <= 16'h0001;
    else run <= run + 16'h0001;
  end
  int_end_a: assert property (
    integrating && read_bytes == 3'h2 && !cmd.valid |->
    period_done == (run == 16'h8000)) else $error("bad internal end");
  ext_end_a: assert property (
    cmd.valid && cmd.code == 8'h30 && read_bytes == 3'h4 |-> period_done)
    else $error("external command did not end period");
  ext_count_a: assert property (
    period_done && read_bytes == 3'h4 |=>
    result.integration_cycle_count == $past(run)) else $error("bad count");
  int_zero_a: assert property (
    period_done && read_bytes == 3'h2 && !cmd.valid |=>
    result.integration_cycle_count == 16'h0) else $error("count not zero");
  latch_data_a: assert property (
    period_done |=> result.sensor_reading == $past(adc_value))
    else $error("reading not latched");
  result_hold_a: assert property (
    !period_done && !cmd.valid |=> $stable(result)) else $error("moved");
  valid_set_a: assert property (
    period_done |=> result_valid) else $error("result not valid");
  mode_pick_a: assert property (
    cmd.valid && cmd.code == 8'h34 |=> read_bytes == 3'h4 &&
    source == integ_timer_pkg::SRC_D2) else $error("mode not taken");
  cover property (period_done && read_bytes == 3'h4);
  cover property (period_done && read_bytes == 3'h2);
  cover property (cmd.valid && cmd.code == 8'h8c);
endmodule : integ_timer_monitor
bind light_adc_integration_timer integ_timer_monitor i_mon (.*);
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, gv, ev) begin samples_checked++; if ((gv) !== (ev)) begin \
  miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, ev, gv); \
  end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] adc = 16'h0000;
  int miscompares = 0;
  int samples_checked = 0;
  integ_timer_pkg::cmd_t cmd;
  integ_timer_pkg::result_t res;
  integ_timer_pkg::source_t src;
  logic iint, ivalid, done, pdn;
  logic [2:0] nbytes;
  always #2 clk = ~clk;
  host_model i_host (.clk(clk), .cmd(cmd));
  light_adc_integration_timer i_dut (.clk(clk), .rst(rst), .cmd(cmd),
    .adc_value(adc), .integrating(iint), .source(src), .result(res),
    .result_valid(ivalid), .period_done(done), .read_bytes(nbytes),
    .powered_down(pdn));
  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Two timing commands a known distance apart
  task automatic ext_run(input int i, input int g);
    adc = 16'h1200 + 16'(i);
    i_host.send(8'h30 + 8'(4 * i), g);
    i_host.send(8'h30 + 8'(4 * i), 0);
    `CHK("count", res.integration_cycle_count, 16'(g + 2))
    `CHK("ext", {res.external, nbytes, ivalid}, 5'h19)
    `CHK("src", res.source, integ_timer_pkg::source_t'(i))
    `CHK("src pin", src, integ_timer_pkg::source_t'(i))
    `CHK("lux", 50000 * res.sensor_reading / res.integration_cycle_count, 50000 * adc / (g + 2))
    `CHK("data", res.sensor_reading, adc)
  endtask : ext_run
  // Self-timed period length and missing count
  task automatic int_run();
    int n = 1;
    adc = 16'h0abc;
    i_host.send(8'h04, 0);
    while (done !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    `CHK("cycles", n, 32768)
    if (n >= 40000) final_report();
    @(negedge clk);
    `CHK("int", {res.integration_cycle_count, nbytes}, 19'h2)
    `CHK("lux", 50000 * res.sensor_reading / 32768, 50000 * 16'h0abc / 32768)
  endtask : int_run
  // Sleep and wake by command
  task automatic power_run();
    i_host.send(8'h8c, 0);
    `CHK("sleep", {pdn, iint}, 2'b10)
    i_host.send(8'h0c, 0);
    `CHK("wake", {pdn, iint}, 2'b00)
  endtask : power_run
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) ext_run(i, 333 * i * i);
    int_run();
    power_run();
    final_report();
  end
endmodule : testbench
`default_nettype wire
